// [rtl/nvp_programmer.sv]
// device end: non-volatile configuration programmer
// Behaviour
// (RL1) only indices 0x73 and 0x74 are nonvolatile cells
// (RL2) program only in forced normal with presets
// (RL3) presets at reset set forced normal mode
// (RL4) preset restore gives system reset, forced normal
// (RL5) host writes cells then check byte
// (RL6) good check starts programming, bad aborts
// (RL7) programming completion issues system reset
// (RL8) cell reads invalid while programming
// (RL9) cells locked after completed programming
// (RL10) host limits programming to 200 cycles
// (RL11) status bit 0 is writable flag, preset 1
// (RL12) six-bit counter bits 7:2 saturates
// (RL13) counter full never blocks programming
// (RL14) status bit 1 reports programming error
// (RL15) crc over 0x73 then 0x74, msb first
// (RL16) crc 8 bits, polynomial 0x2F
// (RL17) crc starts 0xFF, final inversion
// (RL18) preset restore increments program counter
// (RL19) check byte ignored when preconditions fail
`timescale 1ns/1ps
module nvp_programmer
   import nvp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   nvp_link_if.dev link,
   input wire logic preset_restore_i,
   input wire logic prog_fail_i,
   output logic forced_normal_enable_o,
   output logic busy_o
);
   typedef enum logic [1:0] {NVP_IDLE, NVP_PROG, NVP_DONE} nvp_state_e;
   nvp_state_e state_q;
   logic [7:0] startup_q, chipcfg_q, check_q, rdata_q;
   logic [5:0] program_count_q;
   logic program_error_flag_q, nv_writable_flag_q, ack_q, sys_rst_q, fne_q;
   logic [$clog2(NVP_PROG_CYC+1)-1:0] tmr_q;
   // decode of link accesses
   wire wr_hit = link.req && link.wr;
   wire cell_wr_ok = wr_hit && nv_writable_flag_q && (state_q == NVP_IDLE); // see (RL9)
   wire wr_startup = cell_wr_ok && (link.addr == NVP_IDX_STARTUP); // see (RL1)
   wire wr_chipcfg = cell_wr_ok && (link.addr == NVP_IDX_CHIPCFG); // see (RL1)
   wire wr_check = wr_hit && (link.addr == NVP_IDX_CHECK);
   // preconditions: forced normal and cells at presets
   wire can_prog = fne_q && nv_writable_flag_q && (state_q == NVP_IDLE); // see (RL2) (RL19)
   wire [7:0] crc_expect = nvp_crc_byte(nvp_crc_byte(NVP_CRC_INIT, startup_q), chipcfg_q)
      ^ NVP_CRC_XOR; // see (RL15) (RL16) (RL17)
   wire crc_good = (link.wdata == crc_expect);
   wire start_prog = wr_check && can_prog && crc_good; // see (RL6) (RL13)
   wire [5:0] cnt_inc = (program_count_q == NVP_CNT_MAX) ? program_count_q
      : program_count_q + 6'h01; // see (RL12)
   wire prog_end = (state_q == NVP_PROG) && (tmr_q == '0);
   wire [7:0] status_w = {program_count_q, program_error_flag_q, nv_writable_flag_q}; // see (RL11)
   wire in_prog = (state_q == NVP_PROG);
   wire [7:0] rd_mux = (link.addr == NVP_IDX_STATUS) ? status_w :
      (link.addr == NVP_IDX_STARTUP) ? (in_prog ? 8'h00 : startup_q) : // see (RL8)
      (link.addr == NVP_IDX_CHIPCFG) ? (in_prog ? 8'h00 : chipcfg_q) : // see (RL8)
      (link.addr == NVP_IDX_CHECK) ? check_q : 8'h00;

   // cell contents and check byte
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         startup_q <= NVP_RST_STARTUP;
         chipcfg_q <= NVP_RST_CHIPCFG;
         check_q <= 8'h00;
      end else begin
         if (preset_restore_i) begin
            startup_q <= NVP_RST_STARTUP;
            chipcfg_q <= NVP_RST_CHIPCFG;
         end else begin
            if (wr_startup) startup_q <= link.wdata;
            if (wr_chipcfg) chipcfg_q <= link.wdata;
         end
         if (wr_check) check_q <= link.wdata;
      end
   end

   // programming sequencer; rst_i resets status, preset_restore_i resets its flags, sys_rst_q touches none, so status survives the system reset
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= NVP_IDLE;
         tmr_q <= '0;
         program_count_q <= 6'h00;
         program_error_flag_q <= 1'b0;
         nv_writable_flag_q <= 1'b1; // see (RL11)
         sys_rst_q <= 1'b0;
         fne_q <= 1'b1; // see (RL3)
      end else begin
         sys_rst_q <= 1'b0;
         if (preset_restore_i) begin
            state_q <= NVP_IDLE;
            nv_writable_flag_q <= 1'b1;
            program_error_flag_q <= 1'b0;
            program_count_q <= cnt_inc; // see (RL18)
            sys_rst_q <= 1'b1; // see (RL4)
            fne_q <= 1'b1; // see (RL4)
         end else begin
            case (state_q)
               NVP_IDLE: begin
                  if (start_prog) begin
                     state_q <= NVP_PROG;
                     tmr_q <= ($clog2(NVP_PROG_CYC+1))'(NVP_PROG_CYC - 1);
                  end
               end
               NVP_PROG: begin
                  if (prog_end) begin
                     state_q <= NVP_DONE;
                     program_count_q <= cnt_inc; // see (RL12)
                     program_error_flag_q <= prog_fail_i; // see (RL14)
                     nv_writable_flag_q <= 1'b0; // see (RL9)
                     fne_q <= 1'b0;
                  end else begin
                     tmr_q <= tmr_q - 1'b1;
                  end
               end
               NVP_DONE: begin
                  sys_rst_q <= 1'b1; // see (RL7)
                  state_q <= NVP_IDLE;
               end
               default: state_q <= NVP_IDLE;
            endcase
         end
      end
   end

   // link answer one cycle after request
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= link.req && !ack_q;
         rdata_q <= rd_mux;
      end
   end

   assign link.ack = ack_q;
   assign link.rdata = rdata_q;
   assign link.sys_rst = sys_rst_q;
   assign forced_normal_enable_o = fne_q;
   assign busy_o = in_prog;
endmodule

// [rtl/nvp_pkg.sv]
// shared constants and types for the non-volatile configuration programmer
package nvp_pkg;
   // device register indices on the link
   localparam logic [6:0] NVP_IDX_STATUS = 7'h70;
   localparam logic [6:0] NVP_IDX_STARTUP = 7'h73;
   localparam logic [6:0] NVP_IDX_CHIPCFG = 7'h74;
   localparam logic [6:0] NVP_IDX_CHECK = 7'h75;
   // status fields
   localparam int NVP_ST_WRITABLE = 0;
   localparam int NVP_ST_ERROR = 1;
   localparam int NVP_ST_CNT_LO = 2;
   localparam logic [5:0] NVP_CNT_MAX = 6'h3F;
   // crc parameters
   localparam logic [7:0] NVP_CRC_POLY = 8'h2F;
   localparam logic [7:0] NVP_CRC_INIT = 8'hFF;
   localparam logic [7:0] NVP_CRC_XOR = 8'hFF;
   // reset values of the cells
   localparam logic [7:0] NVP_RST_STARTUP = 8'h00;
   localparam logic [7:0] NVP_RST_CHIPCFG = 8'h00;
   // cell programming time
   localparam int NVP_PROG_TIME_US = 10;
   localparam int NVP_CLK_MHZ = 25;
   localparam int NVP_PROG_CYC = NVP_PROG_TIME_US * NVP_CLK_MHZ;
   // controller AHB register byte offsets
   localparam logic [7:0] NVP_A_CMD = 8'h00;
   localparam logic [7:0] NVP_A_WDATA = 8'h04;
   localparam logic [7:0] NVP_A_RDATA = 8'h08;
   localparam logic [7:0] NVP_A_IRQ_ST = 8'h0C;
   localparam logic [7:0] NVP_A_IRQ_EN = 8'h10;
   localparam logic [7:0] NVP_A_IRQ_CLR = 8'h14;
   localparam logic [7:0] NVP_A_BUSY = 8'h18;
   localparam int NVP_CMD_WR = 8;
   // crc step over one byte, msb first
   function automatic logic [7:0] nvp_crc_byte(input logic [7:0] crc, input logic [7:0] b);
      logic [7:0] d;
      d = crc ^ b;
      for (int j = 0; j < 8; j++) begin
         d = d[7] ? ({d[6:0], 1'b0} ^ NVP_CRC_POLY) : {d[6:0], 1'b0};
      end
      return d;
   endfunction
endpackage

// [rtl/nvp_link_if.sv]
// register link between the controller and the programmer
`timescale 1ns/1ps
interface nvp_link_if;
   logic req;
   logic wr;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   logic sys_rst;
   modport dev (input req, input wr, input addr, input wdata,
      output ack, output rdata, output sys_rst);
   modport ctl (output req, output wr, output addr, output wdata,
      input ack, input rdata, input sys_rst);
endinterface

// [rtl/nvp_controller.sv]
// controller end: AHB-Lite registers driving the programmer link
`timescale 1ns/1ps
module nvp_controller
   import nvp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic irq_o,
   nvp_link_if.ctl link
);
   logic ap_q, ap_wr_q, req_q, wr_q, busy_q, irq_q, lk_rst_q;
   logic [7:0] ap_addr_q, rdata_q, wdata_q, st_q, en_q;
   logic [6:0] addr_q;
   // address phase capture
   wire ap = hsel_i && htrans_i[1] && hready_i;
   wire dp_wr = ap_q && ap_wr_q;
   wire cmd_go = dp_wr && (ap_addr_q == NVP_A_CMD) && !busy_q;
   wire clr_w = dp_wr && (ap_addr_q == NVP_A_IRQ_CLR);
   wire done_ev = req_q && link.ack;
   wire rst_ev = link.sys_rst && !lk_rst_q;
   // events: bit0 transfer done, bit1 system reset seen; set wins over clear
   wire [7:0] st_d = (st_q & ~(clr_w ? hwdata_i[7:0] : 8'h00)) | {6'h00, rst_ev, done_ev};
   wire [7:0] rd_mux = (ap_addr_q == NVP_A_WDATA) ? wdata_q :
      (ap_addr_q == NVP_A_RDATA) ? rdata_q :
      (ap_addr_q == NVP_A_IRQ_ST) ? st_q :
      (ap_addr_q == NVP_A_IRQ_EN) ? en_q :
      (ap_addr_q == NVP_A_BUSY) ? {7'h00, busy_q} : 8'h00;

   // bus phase tracking and register writes
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ap_q <= 1'b0;
         ap_wr_q <= 1'b0;
         ap_addr_q <= 8'h00;
         wdata_q <= 8'h00;
         en_q <= 8'h00;
         st_q <= 8'h00;
      end else begin
         ap_q <= ap;
         ap_wr_q <= hwrite_i;
         ap_addr_q <= haddr_i[7:0];
         if (dp_wr && ap_addr_q == NVP_A_WDATA) wdata_q <= hwdata_i[7:0];
         if (dp_wr && ap_addr_q == NVP_A_IRQ_EN) en_q <= hwdata_i[7:0];
         st_q <= st_d;
      end
   end

   // link transfer: command word bits 6:0 index, bit 8 write
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         req_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 7'h00;
         busy_q <= 1'b0;
         rdata_q <= 8'h00;
         lk_rst_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         lk_rst_q <= link.sys_rst;
         irq_q <= |(st_d & en_q);
         if (cmd_go) begin
            req_q <= 1'b1;
            busy_q <= 1'b1;
            wr_q <= hwdata_i[NVP_CMD_WR];
            addr_q <= hwdata_i[6:0];
         end else if (done_ev) begin
            req_q <= 1'b0;
            busy_q <= 1'b0;
            rdata_q <= link.rdata;
         end
      end
   end

   assign hrdata_o = {24'h000000, rd_mux};
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign irq_o = irq_q;
   assign link.req = req_q;
   assign link.wr = wr_q;
   assign link.addr = addr_q;
   assign link.wdata = wdata_q;
endmodule

// [dv/nvp_link_properties.sv]
// link checker for the programmer and its controller
`timescale 1ns/1ps
module nvp_link_checker (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic req,
   input wire logic wr,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   input wire logic sys_rst
);
   logic [9:0] since_q;
   // cycles since a check byte write; saturates so a restore long after stays legal
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i)
         since_q <= 10'h3FF;
      else if (ack && wr && addr == 7'h75)
         since_q <= 10'h000;
      else if (since_q != 10'h3FF)
         since_q <= since_q + 10'h001;
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_ack_on_time: assert property (req && !ack |=> ack)
      else $error("ack late");
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("ack too long");
   a_ack_cause: assert property (ack |-> $past(req))
      else $error("ack without request");
   a_req_steady: assert property (req && !ack |=> req && $stable({wr, addr, wdata}))
      else $error("request changed early");
   a_req_release: assert property (ack |=> !req)
      else $error("request not released");
   a_req_idle: assert property ($rose(req) |-> !ack)
      else $error("request overlaps ack");
   a_sysrst_pulse: assert property (sys_rst |=> !sys_rst)
      else $error("system reset too long");
   a_prog_time: assert property (sys_rst |-> since_q >= 10'd248)
      else $error("system reset too soon");
endmodule

// [dv/nv_config_programmer_test.sv]
// bench: controller and programmer face to face, driven over the register bus
`timescale 1ns/1ps
module nv_config_programmer_test;
   import nvp_pkg::*;
   logic mclk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, pre = 0, fail = 0, er = 0, wb = 1;
   logic hready, hresp, irq, fne, busy;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, t;
   logic [7:0] r;
   logic [5:0] cnt = 0;
   int fails = 0, tests_run = 0;
   always #20 mclk_i = ~mclk_i;
   nvp_link_if ln ();
   nvp_controller nvp_controller_i (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .irq_o(irq), .link(ln));
   nvp_programmer nvp_programmer_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(ln),
      .preset_restore_i(pre), .prog_fail_i(fail), .forced_normal_enable_o(fne), .busy_o(busy));
   nvp_link_checker nvp_link_checker_i (.mclk_i(mclk_i), .rst_i(rst_i), .req(ln.req),
      .wr(ln.wr), .addr(ln.addr), .wdata(ln.wdata), .ack(ln.ack), .rdata(ln.rdata),
      .sys_rst(ln.sys_rst));
   task automatic stop_test();
      $display("compares %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g, input string s);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s exp %h got %h", s, e, g);
      end
   endtask
   // wait for hready at an edge; a stuck bus ends the run
   task automatic rdy();
      int k;
      k = 0;
      do @(posedge mclk_i); while (hready !== 1'b1 && ++k < 50);
      chk(32'h1, {31'h0, hready}, "hready");
      if (k >= 50) stop_test();
   endtask
   // single word: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      t = hrdata;
      chk(32'h0, {31'h0, hresp}, "hresp");
   endtask
   // poll until masked bits match
   task automatic wt(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      int k;
      k = 0;
      do bus(1'b0, a, 32'h0); while ((t & m) !== v && ++k < 400);
      chk(v, t & m, "poll");
      if (k >= 400) stop_test();
   endtask
   // one link transfer via the controller; read data lands in r
   task automatic xf(input logic w, input logic [6:0] i, input logic [7:0] d);
      bus(1'b1, NVP_A_WDATA, {24'h0, d});
      bus(1'b1, NVP_A_CMD, {23'h0, w, 1'b0, i});
      wt(NVP_A_BUSY, 32'h1, 32'h0);
      bus(1'b0, NVP_A_RDATA, 32'h0);
      r = t[7:0];
   endtask
   task automatic st();
      xf(1'b0, NVP_IDX_STATUS, 8'h00);
      chk({24'h0, cnt, er, wb}, {24'h0, r}, "status");
   endtask
   function automatic logic [7:0] crc(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] c;
      c = 8'hFF ^ a;
      for (int i = 0; i < 16; i++) begin
         if (i == 8) c = c ^ b;
         c = c[7] ? {c[6:0], 1'b0} ^ 8'h2F : {c[6:0], 1'b0};
      end
      return c ^ 8'hFF;
   endfunction
   // cells then check byte; ok chooses a good or spoiled check value
   task automatic prog(input logic [7:0] a, input logic [7:0] b, input logic f, input logic ok);
      fail <= f;
      xf(1'b1, NVP_IDX_STARTUP, a);
      xf(1'b1, NVP_IDX_CHIPCFG, b);
      xf(1'b1, NVP_IDX_CHECK, crc(a, b) ^ {7'h0, ~ok});
      chk({31'h0, ok}, {31'h0, busy}, "busy");
      xf(1'b0, NVP_IDX_STARTUP, 8'h00);
      chk({24'h0, ok ? 8'h00 : a}, {24'h0, r}, "cell");
      repeat (ok ? 0 : 300) @(posedge mclk_i);
      wt(NVP_A_IRQ_ST, 32'h2, {30'h0, ok, 1'b0});
      bus(1'b1, NVP_A_IRQ_CLR, 32'h3);
      chk({31'h0, ~ok}, {31'h0, fne}, "fne");
      if (ok) begin
         cnt = cnt + {5'h0, cnt != 6'h3F};
         er = f;
         wb = 1'b0;
      end
      st();
   endtask
   task automatic restore();
      pre <= 1'b1;
      @(posedge mclk_i);
      pre <= 1'b0;
      wt(NVP_A_IRQ_ST, 32'h2, 32'h2);
      bus(1'b1, NVP_A_IRQ_CLR, 32'h3);
      chk(32'h1, {31'h0, fne}, "fne");
      cnt = cnt + {5'h0, cnt != 6'h3F};
      wb = 1'b1;
      st();
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      chk(32'h1, {31'h0, fne}, "fne");
      st();
      $display("reset test done");
      bus(1'b1, NVP_A_IRQ_EN, 32'h1);
      xf(1'b1, NVP_IDX_STARTUP, 8'h5A);
      chk(32'h1, {31'h0, irq}, "irq");
      bus(1'b1, NVP_A_IRQ_CLR, 32'h3);
      bus(1'b0, 8'hFC, 32'h0);
      chk(32'h0, t, "unmapped");
      chk(32'h0, {31'h0, irq}, "irq");
      bus(1'b1, NVP_A_IRQ_EN, 32'h0);
      xf(1'b0, NVP_IDX_STARTUP, 8'h00);
      chk(32'h0, {31'h0, irq}, "irq");
      wt(NVP_A_IRQ_ST, 32'h1, 32'h1);
      $display("interrupt test done");
      prog(8'hA5, 8'h3C, 1'b0, 1'b0);
      prog(8'hA5, 8'h3C, 1'b0, 1'b1);
      xf(1'b1, NVP_IDX_STARTUP, 8'h55);
      xf(1'b0, NVP_IDX_STARTUP, 8'h00);
      chk(32'hA5, {24'h0, r}, "locked");
      xf(1'b1, NVP_IDX_CHECK, crc(8'hA5, 8'h3C));
      chk(32'h0, {31'h0, busy}, "busy");
      repeat (260) @(posedge mclk_i);
      st();
      $display("programming test done");
      restore();
      // about thirty programming cycles, well inside the lifetime limit
      while (cnt != 6'h3F) begin
         prog({2'h0, cnt}, 8'hC3 ^ {2'h0, cnt}, 1'b0, 1'b1);
         restore();
      end
      prog(8'h12, 8'h34, 1'b1, 1'b1);
      $display("counter test done");
      stop_test();
   end
endmodule
